// ==== core/dips_pkg.sv ====
package dips_pkg;

  // Clock and switching timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SWITCH_HZ = 1_200_000;
  localparam int unsigned SWITCH_PERIOD_CYCLES = CLK_HZ / SWITCH_HZ;
  localparam int unsigned MIN_LOW_NS = 100;
  localparam int unsigned MIN_LOW_CYCLES = (MIN_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FILTER_US = 250;
  localparam int unsigned FILTER_CYCLES = FILTER_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SUSPEND_OSC_CYCLES = 6;
  localparam int unsigned DEAD_CYCLES = 1;

  // AXI4-Lite register map
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] DUTY_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] INPUT_ADDR = 8'h0c;

  // Control register fields
  localparam int unsigned CTRL_BUCK_BIT = 0;
  localparam int unsigned CTRL_DEMAND_BIT = 1;
  localparam int unsigned CTRL_HEAVY_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [7:0] DUTY_RESET = 8'h10;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    DIPS_SRC_NONE,
    DIPS_SRC_ONE,
    DIPS_SRC_TWO
  } dips_src_type;

endpackage

// ==== core/dips_control.sv ====
`timescale 1ns/100ps
// Function
// (R1) Select high: run from the higher valid input.
// (R2) Select low: input one whenever its valid is asserted.
// (R3) Priority mode: input one invalid, input two valid, use input two.
// (R4) Highest mode: only one valid input, use that one.
// (R5) Neither input valid: stop all switching, deliver nothing.
// (R6) Higher-input decision is a single comparator bit with hysteresis.
// (R7) Decision change during PWM: all switches off six oscillator cycles.
// (R8) Higher-input decision filtered by a 250 us time constant.
// (R9) No operation until driver supply is above its threshold.
// (R10) Input valid needs supply good, input above undervoltage, run enable high.
// (R11) Open-drain good flags pull low while input valid, also when skipping.
// (R12) Input one selected: pump one and switch one active, path two off.
// (R13) Input two selected: pump two and switch two active, path one off.
// (R14) Mode high or heavy load: fixed PWM at 1.2 MHz.
// (R15) PWM: both switch nodes toggle every cycle.
// (R16) Buck: output high switch on except 100 ns low, low switch then.
// (R17) Buck: duty modulated on input high and input low switches.
// (R18) Boost: input high switch on except 100 ns low, input low then.
// (R19) Boost: duty modulated on output low and output high switches.
// (R20) Skip mode moves to PWM automatically when load rises. The code moves only when software sets CTRL_HEAVY_BIT.
// (R21) Skip mode switches only when regulation needs it, else idle.
// (R22) Mode low selects automatic skipping, mode high forced PWM.
// (R23) Both input paths never enabled together, even at changeover.
// (R24) Break-before-make on each switch node.
module dips_control
  import dips_pkg::*;
#(
  parameter int unsigned FILTER_LEN = dips_pkg::FILTER_CYCLES,
  parameter int unsigned PERIOD = dips_pkg::SWITCH_PERIOD_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic source_select,
  input wire logic mode_pwm,
  input wire logic driver_supply_ok,
  input wire logic input1_above_uvlo,
  input wire logic input2_above_uvlo,
  input wire logic input1_run_enable,
  input wire logic input2_run_enable,
  input wire logic input1_higher,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic input1_good_flag_n_o,
  output logic input1_good_flag_n_oe,
  output logic input2_good_flag_n_o,
  output logic input2_good_flag_n_oe,
  output logic path1_charge_pump,
  output logic path2_charge_pump,
  output logic input1_high_switch,
  output logic input2_high_switch,
  output logic input_low_switch,
  output logic output_high_switch,
  output logic output_low_switch
);
  import dips_pkg::*;

  // Eight-bit phase counter needs room for two minimum low intervals
  if (PERIOD < 2 * MIN_LOW_CYCLES + 4 || PERIOD > 255 || FILTER_LEN < 1)
  begin
    $error("dips_control: unsupported period or filter length");
  end

  // ==========================================================
  // Input qualification
  logic input1_valid;
  logic input2_valid;
  logic v1_q;
  logic v2_q;
  assign input1_valid = driver_supply_ok & input1_above_uvlo & input1_run_enable; // (R9) (R10)
  assign input2_valid = driver_supply_ok & input2_above_uvlo & input2_run_enable; // (R9) (R10)

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      v1_q <= 1'b0;
      v2_q <= 1'b0;
    end
    else
    begin
      v1_q <= input1_valid;
      v2_q <= input2_valid;
    end
  end

  // Flags pull low regardless of switching mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      input1_good_flag_n_oe <= 1'b0;
      input2_good_flag_n_oe <= 1'b0;
      input1_good_flag_n_o <= 1'b0;
      input2_good_flag_n_o <= 1'b0;
    end
    else
    begin
      input1_good_flag_n_oe <= input1_valid; // (R11)
      input2_good_flag_n_oe <= input2_valid; // (R11)
      input1_good_flag_n_o <= 1'b0;
      input2_good_flag_n_o <= 1'b0;
    end
  end

  // ==========================================================
  // Higher-input filter
  // Comparator already has hysteresis; filter adds time so sources do not chatter
  logic higher_filt_q;
  logic [31:0] filt_cnt_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      higher_filt_q <= 1'b1;
      filt_cnt_q <= 32'h0000_0000;
    end
    else if (input1_higher == higher_filt_q) // (R6)
    begin
      filt_cnt_q <= 32'h0000_0000;
    end
    else if (filt_cnt_q >= 32'(FILTER_LEN - 1)) // (R8)
    begin
      higher_filt_q <= input1_higher;
      filt_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      filt_cnt_q <= filt_cnt_q + 32'h0000_0001;
    end
  end

  // ==========================================================
  // Source decode
  dips_src_type src_d;
  dips_src_type src_q;
  always_comb
  begin
    src_d = DIPS_SRC_NONE; // (R5)
    if (v1_q && !(source_select && v2_q && !higher_filt_q))
    begin
      src_d = DIPS_SRC_ONE; // (R1) (R2) (R4)
    end
    else if (v2_q)
    begin
      src_d = DIPS_SRC_TWO; // (R1) (R3) (R4)
    end
  end

  // ==========================================================
  // Registers
  logic [31:0] ctrl_q;
  logic [7:0] duty_q;
  logic pwm_active;
  assign pwm_active = mode_pwm | ctrl_q[CTRL_HEAVY_BIT]; // (R14) (R20) (R22)

  // ==========================================================
  // Oscillator and suspension
  logic [7:0] phase_q;
  logic cycle_start;
  logic [2:0] suspend_q;
  assign cycle_start = (phase_q == 8'h00);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_q <= 8'h00;
    end
    else if (phase_q == 8'(PERIOD - 1))
    begin
      phase_q <= 8'h00;
    end
    else
    begin
      phase_q <= phase_q + 8'h01;
    end
  end

  // Changeover in PWM: suspend for six oscillator periods, old path drops first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_q <= DIPS_SRC_NONE;
      suspend_q <= 3'h0;
    end
    else if (src_d != src_q)
    begin
      src_q <= src_d;
      if (pwm_active && src_q != DIPS_SRC_NONE && src_d != DIPS_SRC_NONE)
      begin
        // Partial first period does not count towards the six
        suspend_q <= 3'(SUSPEND_OSC_CYCLES + 1); // (R7)
      end
    end
    else if (cycle_start && suspend_q != 3'h0)
    begin
      suspend_q <= suspend_q - 3'h1; // (R7)
    end
  end

  // ==========================================================
  // Switch timing
  logic run;
  logic burst_ok;
  logic [7:0] duty_eff;
  logic [7:0] hi_end;
  logic [7:0] min_end;
  logic a_on;
  logic b_on;
  logic c_on;
  logic d_on;
  logic buck;
  assign buck = ctrl_q[CTRL_BUCK_BIT];
  assign burst_ok = pwm_active | ctrl_q[CTRL_DEMAND_BIT]; // (R21)
  assign run = (src_q != DIPS_SRC_NONE) && (suspend_q == 3'h0) && burst_ok; // (R5) (R7)
  assign min_end = 8'(PERIOD - MIN_LOW_CYCLES);
  assign duty_eff = (duty_q > min_end - 8'(DEAD_CYCLES)) ? min_end - 8'(DEAD_CYCLES) :
    ((duty_q < 8'(DEAD_CYCLES + 1)) ? 8'(DEAD_CYCLES + 1) : duty_q);
  assign hi_end = buck ? duty_eff : min_end;

  // Dead cycle between high and low on each node
  always_comb
  begin
    a_on = run && phase_q < hi_end; // (R17) (R18)
    b_on = run && phase_q >= hi_end + 8'(DEAD_CYCLES) && phase_q < 8'(PERIOD - DEAD_CYCLES); // (R24)
    if (buck)
    begin
      d_on = run && phase_q < min_end; // (R16)
      c_on = run && phase_q >= min_end + 8'(DEAD_CYCLES) && phase_q < 8'(PERIOD - DEAD_CYCLES); // (R16)
    end
    else
    begin
      c_on = run && phase_q < duty_eff; // (R19)
      d_on = run && phase_q >= duty_eff + 8'(DEAD_CYCLES) && phase_q < 8'(PERIOD - DEAD_CYCLES); // (R19)
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      path1_charge_pump <= 1'b0;
      path2_charge_pump <= 1'b0;
      input1_high_switch <= 1'b0;
      input2_high_switch <= 1'b0;
      input_low_switch <= 1'b0;
      output_high_switch <= 1'b0;
      output_low_switch <= 1'b0;
    end
    else
    begin
      // Pumps need src_q and src_d to agree so both can never be high together
      path1_charge_pump <= (src_q == DIPS_SRC_ONE) && (src_d == DIPS_SRC_ONE); // (R12) (R23)
      path2_charge_pump <= (src_q == DIPS_SRC_TWO) && (src_d == DIPS_SRC_TWO); // (R13) (R23)
      input1_high_switch <= a_on && src_q == DIPS_SRC_ONE && src_d == DIPS_SRC_ONE; // (R12)
      input2_high_switch <= a_on && src_q == DIPS_SRC_TWO && src_d == DIPS_SRC_TWO; // (R13)
      input_low_switch <= b_on; // (R15)
      output_high_switch <= d_on; // (R15)
      output_low_switch <= c_on; // (R15)
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  // Ready low means the word is held and not yet consumed
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        aw_addr_q <= s_axi_awaddr[7:0];
      end
      else if (do_write)
      begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (do_write)
      begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= CTRL_RESET;
      duty_q <= DUTY_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= RESP_OKAY;
      if (aw_addr_q == CTRL_ADDR && w_strb_q[0])
      begin
        ctrl_q <= {29'h0, w_data_q[2:0]};
      end
      else if (aw_addr_q == DUTY_ADDR && w_strb_q[0])
      begin
        duty_q <= w_data_q[7:0];
      end
      else if (aw_addr_q != CTRL_ADDR && aw_addr_q != DUTY_ADDR)
      begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
    else if (s_axi_arvalid && !s_axi_arready)
    begin
      s_axi_arready <= 1'b1;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr[7:0])
        CTRL_ADDR: s_axi_rdata <= ctrl_q;
        DUTY_ADDR: s_axi_rdata <= {24'h0, duty_q};
        STATUS_ADDR: s_axi_rdata <= {24'h0, run, suspend_q, 2'(src_q), v2_q, v1_q};
        INPUT_ADDR: s_axi_rdata <= {27'h0, higher_filt_q, input1_higher, mode_pwm,
          source_select, driver_supply_ok};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
  end

endmodule

// ==== sim/dips_control_chk.sv ====
`timescale 1ns/100ps
// ==========
// Gate and flag checks
module dips_control_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic source_select,
  input wire logic driver_supply_ok,
  input wire logic input1_above_uvlo,
  input wire logic input2_above_uvlo,
  input wire logic input1_run_enable,
  input wire logic input2_run_enable,
  input wire logic input1_good_flag_n_o,
  input wire logic input1_good_flag_n_oe,
  input wire logic input2_good_flag_n_o,
  input wire logic input2_good_flag_n_oe,
  input wire logic path1_charge_pump,
  input wire logic path2_charge_pump,
  input wire logic input1_high_switch,
  input wire logic input2_high_switch,
  input wire logic input_low_switch,
  input wire logic output_high_switch,
  input wire logic output_low_switch
);
  logic v1;
  logic v2;
  logic hs;
  logic any_on;
  assign v1 = driver_supply_ok && input1_above_uvlo && input1_run_enable;
  assign v2 = driver_supply_ok && input2_above_uvlo && input2_run_enable;
  assign hs = input1_high_switch || input2_high_switch;
  assign any_on = hs || input_low_switch || output_high_switch || output_low_switch;
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Five edges span the valid, select and gate stages
  sequence none_valid;
    (!v1 && !v2)[*5];
  endsequence
  sequence only_two;
    (!v1 && v2)[*5];
  endsequence
  sequence first_prio;
    (!source_select && v1)[*5];
  endsequence
  a_pump_excl: assert property (!(path1_charge_pump && path2_charge_pump))
    else $error("both pumps on");
  a_high_excl: assert property (!(input1_high_switch && input2_high_switch))
    else $error("both input high switches on");
  a_in_node_bbm: assert property (!(hs && input_low_switch))
    else $error("input node shoot through");
  a_out_node_bbm: assert property (!(output_high_switch && output_low_switch))
    else $error("output node shoot through");
  a_flag1_valid: assert property ($past(aresetn) |-> input1_good_flag_n_oe == $past(v1))
    else $error("flag one not following validity");
  a_flag2_valid: assert property ($past(aresetn) |-> input2_good_flag_n_oe == $past(v2))
    else $error("flag two not following validity");
  a_flag_pull_low: assert property (!input1_good_flag_n_o && !input2_good_flag_n_o)
    else $error("flag drives high");
  a_idle_no_input: assert property (none_valid |-> !any_on && !path1_charge_pump
    && !path2_charge_pump)
    else $error("activity with no valid input");
  a_prio_first: assert property (first_prio |-> !path2_charge_pump && !input2_high_switch)
    else $error("path two active in priority");
  a_only_second: assert property (only_two |-> !path1_charge_pump && !input1_high_switch)
    else $error("path one active without its input");
endmodule

// ==== sim/dips_far_side.sv ====
`timescale 1ns/100ps
// ==========
// Indicator pull-ups
module dips_far_side (
  input wire logic input1_good_flag_n_o,
  input wire logic input1_good_flag_n_oe,
  input wire logic input2_good_flag_n_o,
  input wire logic input2_good_flag_n_oe,
  output logic input1_good_pin,
  output logic input2_good_pin
);
  // Released pin floats to the pull-up level
  assign input1_good_pin = input1_good_flag_n_oe ? input1_good_flag_n_o : 1'b1;
  assign input2_good_pin = input2_good_flag_n_oe ? input2_good_flag_n_o : 1'b1;
endmodule

// ==== sim/dips_tb.sv ====
`timescale 1ns/100ps
// ==========
// Bench
module tb;
  import dips_pkg::*;
  localparam int PER = 33;
  logic aclk = 1'b0, aresetn = 1'b0, source_select = 1'b0, mode_pwm = 1'b1;
  logic driver_supply_ok = 1'b1, input1_above_uvlo = 1'b1, input2_above_uvlo = 1'b1;
  logic input1_run_enable = 1'b1, input2_run_enable = 1'b1, input1_higher = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic input1_good_flag_n_o, input1_good_flag_n_oe, input2_good_flag_n_o;
  logic input2_good_flag_n_oe, path1_charge_pump, path2_charge_pump;
  logic input1_high_switch, input2_high_switch, input_low_switch;
  logic output_high_switch, output_low_switch, input1_good_pin, input2_good_pin;
  logic low_q = 1'b0;
  int bad_count = 0, num_checks = 0, run = 0, gap = 0, quiet = 0, qm;
  int h1, h2, oh, ol, il;

  always #12.5 aclk = ~aclk;

  dips_control #(.FILTER_LEN(8), .PERIOD(PER)) u_dut (.*);
  dips_far_side u_far (.*);

  // ==========
  // Gate activity watch
  always @(posedge aclk)
  begin
    low_q <= input_low_switch;
    if (input_low_switch && !low_q) gap <= run;
    run <= (input_low_switch && !low_q) ? 1 : run + 1;
    quiet <= (input1_high_switch || input2_high_switch || input_low_switch ||
      output_high_switch || output_low_switch) ? 0 : quiet + 1;
  end

  // ==========
  // Common tasks
  task wrap_up;
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Ends on a rising edge so the next drive is race free
  task watch(input int n);
    qm = 0;
    repeat (n)
    begin
      @(negedge aclk);
      if (quiet > qm) qm = quiet;
    end
    @(posedge aclk);
  endtask

  task meas;
    h1 = 0; h2 = 0; oh = 0; ol = 0; il = 0;
    repeat (PER)
    begin
      @(negedge aclk);
      h1 += input1_high_switch;
      h2 += input2_high_switch;
      oh += output_high_switch;
      ol += output_low_switch;
      il += input_low_switch;
    end
    @(posedge aclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 100) bad_count++;
    if (n == 100) wrap_up();
  endtask

  task rd_reg(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 100) bad_count++;
    if (n == 100) wrap_up();
  endtask

  // ==========
  // Scenarios
  task t_regs;
    rd_reg(CTRL_ADDR);
    chk(rd, CTRL_RESET);
    rd_reg(DUTY_ADDR);
    chk(rd[7:0], DUTY_RESET);
    rd_reg(INPUT_ADDR);
    chk(rd[4:0], 5'h1d);
    rd_reg(8'h10);
    chk(rd, 32'h0);
    chk(resp, RESP_SLVERR);
    rd_reg(STATUS_ADDR);
    chk(rd[7:0], 8'h87);
    wr(8'h14, 32'h0);
    chk(resp, RESP_SLVERR);
  endtask

  task t_select;
    logic e1;
    for (int i = 0; i < 16; i++)
    begin
      source_select <= i[2];
      input1_run_enable <= i[1];
      input2_above_uvlo <= i[0];
      input1_higher <= i[3];
      cyc(250);
      e1 = i[1] && (!i[2] || !i[0] || i[3]);
      chk(path1_charge_pump, e1);
      chk(path2_charge_pump, i[0] && !e1);
      chk(input1_good_pin, !i[1]);
      chk(input2_good_pin, !i[0]);
    end
    driver_supply_ok <= 1'b0;
    cyc(20);
    chk({path1_charge_pump, input1_good_pin, input2_good_pin}, 3'h3);
    driver_supply_ok <= 1'b1;
    input1_above_uvlo <= 1'b0;
    input2_run_enable <= 1'b0;
    cyc(20);
    chk({path1_charge_pump, path2_charge_pump, input1_good_pin, input2_good_pin}, 4'h3);
    input1_above_uvlo <= 1'b1;
    input2_run_enable <= 1'b1;
    source_select <= 1'b0;
    cyc(250);
  endtask

  task t_pwm;
    wr(DUTY_ADDR, 32'h8);
    cyc(2 * PER);
    meas();
    chk(h1, 8);
    chk(h2, 0);
    chk(oh >= PER - MIN_LOW_CYCLES - 2 && oh < PER, 32'h1);
    chk(ol > 0 && il > 0, 32'h1);
    chk(gap, PER);
    wr(DUTY_ADDR, 32'hff);
    cyc(2 * PER);
    meas();
    chk(h1, PER - 5);
    wr(CTRL_ADDR, 32'h0);
    cyc(2 * PER);
    meas();
    chk(h1 >= PER - MIN_LOW_CYCLES - 2 && h1 < PER, 32'h1);
    chk(ol > 0 && oh > 0 && il > 0, 32'h1);
    chk(gap, PER);
    wr(CTRL_ADDR, 32'h1);
    wr(DUTY_ADDR, {24'h0, DUTY_RESET});
  endtask

  task t_change;
    source_select <= 1'b1;
    cyc(250);
    input1_higher <= 1'b0;
    cyc(3);
    input1_higher <= 1'b1;
    cyc(60);
    chk(path1_charge_pump, 1'b1);
    input1_higher <= 1'b0;
    watch(300);
    chk(path2_charge_pump, 1'b1);
    chk(qm >= 6 * PER && qm < 8 * PER, 32'h1);
  endtask

  // Skip demand comes from software, so the bench plays the load
  task t_skip;
    mode_pwm <= 1'b0;
    watch(150);
    chk(qm >= 100, 32'h1);
    chk(input2_good_pin, 1'b0);
    wr(CTRL_ADDR, 32'h3);
    watch(2 * PER);
    chk(quiet < PER, 32'h1);
    wr(CTRL_ADDR, 32'h5);
    watch(2 * PER);
    chk(quiet < PER, 32'h1);
    wr(CTRL_ADDR, 32'h1);
    mode_pwm <= 1'b1;
    watch(2 * PER);
    chk(quiet < PER, 32'h1);
  endtask

  initial
  begin
    cyc(6);
    aresetn <= 1'b1;
    t_regs();
    t_select();
    t_pwm();
    t_change();
    t_skip();
    wrap_up();
  end
endmodule

bind dips_control dips_control_chk u_chk (.*);
